//--- bench/rtc_control_asserts.sv
`timescale 1ns/100ps
`default_nettype none
module rtc_control_asserts
  import rtc_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_sys_reset,
  input wire rtc_pkg::apb_req_s i_apb,
  input wire rtc_pkg::apb_rsp_s o_apb,
  input wire logic o_rtc_pin,
  input wire logic o_rtc_pin_oe_n
);
  logic mapped;

  assign mapped = (i_apb.paddr <= OFS_AW_LO) && (i_apb.paddr[1:0] == 2'h0);

  default clocking @(posedge i_clk); endclocking
  default disable iff (i_reset || i_sys_reset);

  // ********************************************************
  // Bus handshake
  // ********************************************************
  sequence setup_s;
    i_apb.psel && !i_apb.penable;
  endsequence
  sequence access_s;
    i_apb.psel && i_apb.penable && !o_apb.pready;
  endsequence
  sequence cfg_wr_s;
    o_apb.pready && i_apb.pwrite && (i_apb.paddr == OFS_CONFIG);
  endsequence

  ready_wait_a: assert property (setup_s ##1 access_s |=> o_apb.pready)
    else $error("pready late after access phase");
  ready_pulse_a: assert property (o_apb.pready |=> !o_apb.pready)
    else $error("pready held longer than one cycle");
  ready_in_xfer_a: assert property (o_apb.pready |->
    i_apb.psel && i_apb.penable)
    else $error("pready outside a transfer");
  unmapped_err_a: assert property (o_apb.pready && !mapped |->
    o_apb.pslverr && (o_apb.prdata == 32'h0))
    else $error("unmapped access not refused");
  mapped_ok_a: assert property (o_apb.pready && mapped |->
    !o_apb.pslverr && (o_apb.prdata[31:8] == 24'h0))
    else $error("mapped access answered wrongly");
  cfg_spare_a: assert property (o_apb.pready && !i_apb.pwrite &&
    (i_apb.paddr == OFS_CONFIG) |-> !o_apb.prdata[6])
    else $error("config spare bit reads one");
  pin_bits_a: assert property (o_apb.pready && !i_apb.pwrite &&
    (i_apb.paddr == OFS_PIN) |->
    (o_apb.prdata[7:3] == 5'h0) && !o_apb.prdata[0])
    else $error("pin config spare bits read one");

  // ********************************************************
  // Pin
  // ********************************************************
  pin_reset_a: assert property ($fell(i_reset) |->
    o_rtc_pin_oe_n && !o_rtc_pin)
    else $error("pin not idle after reset");
  pin_quiet_a: assert property (o_rtc_pin_oe_n |-> !o_rtc_pin)
    else $error("pin driven while output disabled");
  pin_on_a: assert property (cfg_wr_s ##0 i_apb.pwdata[CFG_OE] |->
    ##[1:3] !o_rtc_pin_oe_n)
    else $error("pin output not enabled");
  pin_off_a: assert property (cfg_wr_s ##0 !i_apb.pwdata[CFG_OE] |->
    ##[1:3] o_rtc_pin_oe_n)
    else $error("pin output not disabled");
endmodule // rtc_control_asserts

bind rtc_control rtc_control_asserts u_rtc_control_asserts (
  .i_clk(i_clk),
  .i_reset(i_reset),
  .i_sys_reset(i_sys_reset),
  .i_apb(i_apb),
  .o_apb(o_apb),
  .o_rtc_pin(o_rtc_pin),
  .o_rtc_pin_oe_n(o_rtc_pin_oe_n)
);
`default_nettype wire

//--- bench/rtc_control_tb.sv
`timescale 1ns/100ps
`default_nettype none
module rtc_control_tb;
  import rtc_pkg::*;
  logic i_clk = 1'b0;
  logic i_reset = 1'b1;
  logic i_sys_reset = 1'b0;
  logic [1:0] tk_div = 2'h0;
  apb_req_s apb_req = '0;
  apb_rsp_s apb_rsp;
  logic o_rtc_pin;
  logic o_rtc_pin_oe_n;
  logic [7:0] rd_v;
  int errors = 0;
  int checks_done = 0;
  logic [11:0] ctl_ofs [5] =
    '{OFS_CONFIG, OFS_TRIM, OFS_PIN, OFS_ALM_CFG, OFS_RPT};

  // ********************************************************
  // Clocks and design
  // ********************************************************
  always #50 i_clk = ~i_clk;
  // A fast timekeeping clock keeps the half-second test short.
  always @(posedge i_clk) tk_div <= tk_div + 2'h1;

  rtc_control u_rtc_control (
    .i_clk(i_clk),
    .i_reset(i_reset),
    .i_sys_reset(i_sys_reset),
    .i_ce(1'b1),
    .i_tk_clk(tk_div[1]),
    .i_apb(apb_req),
    .o_apb(apb_rsp),
    .o_rtc_pin(o_rtc_pin),
    .o_rtc_pin_oe_n(o_rtc_pin_oe_n)
  );

  // ********************************************************
  // Tasks
  // ********************************************************
  task automatic check(input string nm, input logic [7:0] seen,
                       input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic xfer(input logic w, input logic [11:0] a,
                      input logic [7:0] d);
    int n;
    @(posedge i_clk);
    apb_req.psel <= 1'b1;
    apb_req.penable <= 1'b0;
    apb_req.pwrite <= w;
    apb_req.paddr <= a;
    apb_req.pwdata <= {24'h0, d};
    @(posedge i_clk);
    apb_req.penable <= 1'b1;
    n = 0;
    do begin
      @(posedge i_clk);
      n++;
    end while (apb_rsp.pready !== 1'b1 && n < 20);
    check("pready", {7'h0, apb_rsp.pready}, 8'h01);
    rd_v = apb_rsp.prdata[7:0];
    apb_req.psel <= 1'b0;
    apb_req.penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    xfer(1'b1, a, d);
  endtask

  task automatic rc(input string nm, input logic [11:0] a,
                    input logic [7:0] exp);
    xfer(1'b0, a, 8'h00);
    check(nm, rd_v, exp);
  endtask

  task automatic give_verdict;
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // ********************************************************
  // Tests
  // ********************************************************
  initial begin
    repeat (90000) @(posedge i_clk);
    errors++;
    give_verdict();
  end

  initial begin
    repeat (10) @(posedge i_clk);
    i_reset <= 1'b0;
    foreach (ctl_ofs[i])
      rc("reset", ctl_ofs[i], 8'h00);
    xfer(1'b0, 12'h024, 8'h00);
    check("unmapped", {7'h0, apb_rsp.pslverr}, 8'h01);
    wr(OFS_CONFIG, 8'h80);
    rc("locked on", OFS_CONFIG, 8'h00);
    wr(OFS_TW_LO, 8'h37);
    rc("locked sec", OFS_TW_LO, 8'h00);
    wr(OFS_CONFIG, 8'h20);
    wr(OFS_CONFIG, 8'hA3);
    rc("unlocked on", OFS_CONFIG, 8'hA3);
    wr(OFS_TW_HI, 8'h00);
    wr(OFS_TW_HI, 8'h12);
    wr(OFS_TW_HI, 8'h05);
    wr(OFS_TW_HI, 8'h45);
    rc("tptr zero", OFS_CONFIG, 8'hA0);
    rc("minutes", OFS_TW_HI, 8'h45);
    wr(OFS_CONFIG, 8'hA2);
    rc("day", OFS_TW_LO, 8'h01);
    rc("month", OFS_TW_HI, 8'h12);
    rc("weekday", OFS_TW_HI, 8'h05);
    rc("tptr end", OFS_CONFIG, 8'hA0);
    wr(OFS_ALM_CFG, 8'h02);
    wr(OFS_AW_HI, 8'h11);
    wr(OFS_ALM_CFG, 8'h02);
    rc("alarm month", OFS_AW_HI, 8'h11);
    rc("aptr step", OFS_ALM_CFG, 8'h01);
    rc("alarm hour", OFS_AW_LO, 8'h00);
    rc("alarm wday", OFS_AW_HI, 8'h00);
    rc("aptr zero", OFS_ALM_CFG, 8'h00);
    wr(OFS_TRIM, 8'h80);
    rc("trim", OFS_TRIM, 8'h80);
    wr(OFS_TRIM, 8'h00);
    wr(OFS_PIN, 8'hFF);
    rc("pin cfg", OFS_PIN, 8'h06);
    wr(OFS_PIN, 8'h00);
    wr(OFS_CONFIG, 8'hA4);
    repeat (3) @(posedge i_clk);
    check("pin oe", {7'h0, o_rtc_pin_oe_n}, 8'h00);
    i_sys_reset <= 1'b1;
    repeat (3) @(posedge i_clk);
    i_sys_reset <= 1'b0;
    rc("cfg kept", OFS_CONFIG, 8'hA4);
    // The seconds write restarts the prescaler, so the half tick is known.
    wr(OFS_ALM_CFG, 8'h80);
    wr(OFS_TW_LO, 8'h37);
    rc("seconds", OFS_TW_LO, 8'h37);
    repeat (60000) @(posedge i_clk);
    rc("first half", OFS_CONFIG, 8'hA4);
    check("pin low", {7'h0, o_rtc_pin}, 8'h00);
    repeat (7000) @(posedge i_clk);
    rc("second half", OFS_CONFIG, 8'hAC);
    check("alarm pulse", {7'h0, o_rtc_pin}, 8'h01);
    rc("alarm off", OFS_ALM_CFG, 8'h00);
    rc("no wrap", OFS_RPT, 8'h00);
    give_verdict();
  end
endmodule // rtc_control_tb
`default_nettype wire

//--- hw/bcd_field.sv
`timescale 1ns/100ps
`default_nettype none
module bcd_field #(
  parameter logic [7:0] RESET_VAL = 8'h00
) (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_ce,
  input wire logic i_inc,
  input wire logic i_load,
  input wire logic [7:0] i_load_val,
  input wire logic [7:0] i_min,
  input wire logic [7:0] i_max,
  output logic [7:0] o_value,
  output logic o_at_max
);
  logic [7:0] value_q;

  assign o_value = value_q;
  // A day left above a shorter month's end still wraps.
  assign o_at_max = (value_q >= i_max);

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      value_q <= RESET_VAL;
    end else if (i_ce) begin
      if (i_load) begin
        value_q <= i_load_val;
      end else if (i_inc) begin
        if (o_at_max) begin
          value_q <= i_min;
        end else if (value_q[3:0] == 4'h9) begin
          value_q <= {value_q[7:4] + 4'h1, 4'h0};
        end else begin
          value_q <= {value_q[7:4], value_q[3:0] + 4'h1};
        end
      end
    end
  end
endmodule // bcd_field
`default_nettype wire

//--- hw/rtc_control.sv
`timescale 1ns/100ps
`default_nettype none
// Notes on behaviour
// (R1) Module-on bit 1 runs timekeeping, 0 stops it.
// (R2) Module-on writes are dropped unless the write unlock is already 1.
// (R3) Time window writes only take effect while write unlock is 1.
// (R4) Rollover flag warns of ripple; software reads twice and compares.
// (R5) Half-second flag reads 1 in the second half of each second.
// (R6) Writing seconds clears the half-second flag.
// (R7) Pin drives the selection only while pin output enable is 1.
// (R8) Time pointer decrements on each high window access, stops at 0.
// (R9) Time pointer picks minute/weekday/month high, sec/hour/day/year low.
// (R10) Only power-on reset clears configuration; time keeps running.
// (R11) Signed trim, four source pulses per step per minute.
// (R12) Select 0 alarm pulse, 1 seconds clock, 2 source clock.
// (R13) Alarm enable self-clears when counter is 0 and no endless repeat.
// (R14) Repeat counter decrements on every alarm event, except at 00h without endless repeat.
// (R15) Counter gives the number of further alarms after this one.
// (R16) Counter wraps 00h to FFh only with endless repeat set.
// (R17) Interval codes 0 to 9 pick half second up to yearly.
// (R18) Yearly alarm on February 29 fires only in leap years.
// (R19) Alarm pointer decrements on each high window access, stops at 0.
// (R20) Alarm pointer picks minute/weekday/month high, sec/hour/day low.
// (R21) Calendar years 2000 to 2099, 24-hour, leap years handled.
// (R22) Seconds and minutes hold BCD tens 0 to 5 and ones 0 to 9.
// (R23) Alarm fires one pulse when unmasked fields match the time.
// (R24) Trim is applied at each minute boundary in the prescaler.
module rtc_control
  import rtc_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_sys_reset,
  input wire logic i_ce,
  input wire logic i_tk_clk,
  input wire rtc_pkg::apb_req_s i_apb,
  output rtc_pkg::apb_rsp_s o_apb,
  output logic o_rtc_pin,
  output logic o_rtc_pin_oe_n
);
  import rtc_pkg::*;

  // ********************************************************
  // Source clock sampling
  // ********************************************************
  logic tk_s1_q;
  logic tk_s2_q;
  logic tk_s3_q;
  logic tick;

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      tk_s1_q <= 1'b0;
      tk_s2_q <= 1'b0;
      tk_s3_q <= 1'b0;
    end else if (i_ce) begin
      tk_s1_q <= i_tk_clk;
      tk_s2_q <= tk_s1_q;
      tk_s3_q <= tk_s2_q;
    end
  end

  assign tick = tk_s2_q & ~tk_s3_q;

  // ********************************************************
  // Bus decode
  // ********************************************************
  logic pready_q;
  logic [31:0] prdata_q;
  logic pslverr_q;
  logic fire;
  logic wr;
  logic [11:0] addr;
  logic [7:0] wdata;

  assign addr = i_apb.paddr;
  assign wdata = i_apb.pwdata[7:0];
  assign fire = i_apb.psel & i_apb.penable & pready_q;
  assign wr = fire & i_apb.pwrite;

  // Window slot for a pointer value; alarms have no year.
  function automatic logic [2:0] slot(
    input logic hi,
    input logic [1:0] ptr,
    input logic alarm
  );
    logic [2:0] s;
    s = F_NONE;
    case (ptr)
      2'h0: s = hi ? F_MIN : F_SEC;
      2'h1: s = hi ? F_WDAY : F_HOUR;
      2'h2: s = hi ? F_MONTH : F_DAY;
      default: s = (hi || alarm) ? F_NONE : F_YEAR;
    endcase
    return s;
  endfunction

  // ********************************************************
  // Configuration registers
  // ********************************************************
  logic on_q;
  logic unlock_q;
  logic oe_q;
  logic [1:0] tptr_q;
  logic [7:0] trim_q;
  logic [1:0] sel_q;

  // Only the power-on reset reaches these flops. (R10)
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      on_q <= 1'b0;
      unlock_q <= 1'b0;
      oe_q <= 1'b0;
      tptr_q <= 2'h0;
    end else if (i_ce) begin
      if (wr && addr == OFS_CONFIG) begin
        unlock_q <= wdata[CFG_UNLOCK];
        oe_q <= wdata[CFG_OE];
        tptr_q <= wdata[1:0];
        if (unlock_q) begin // (R2)
          on_q <= wdata[CFG_ON];
        end
      end else if (fire && addr == OFS_TW_HI && tptr_q != 2'h0) begin
        tptr_q <= tptr_q - 2'h1; // (R8)
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      trim_q <= REG_RESET;
      sel_q <= 2'h0;
    end else if (i_ce) begin
      if (wr && addr == OFS_TRIM) begin
        trim_q <= wdata;
      end
      if (wr && addr == OFS_PIN) begin
        sel_q <= wdata[2:1];
      end
    end
  end

  // ********************************************************
  // Timekeeping
  // ********************************************************
  logic sec_tick;
  logic half_tick;
  logic half_flag;
  logic near_roll;
  logic [2:0] tw_slot;
  logic t_load;
  logic [7:0] fval [6];
  logic [5:0] at_max;
  logic [6:0] carry;
  logic [7:0] day_max;
  logic leap;
  logic [2:0] wday_q;

  assign tw_slot = slot(addr == OFS_TW_HI, tptr_q, 1'b0);
  assign t_load = wr && unlock_q // (R3)
    && (addr == OFS_TW_HI || addr == OFS_TW_LO);

  tick_prescaler u_pre (
    .i_clk(i_clk),
    .i_reset(i_reset),
    .i_ce(i_ce),
    .i_tick(tick),
    .i_run(on_q), // (R1)
    .i_clear(t_load && tw_slot == F_SEC), // (R6)
    .i_sec_at_max(at_max[F_SEC]),
    .i_trim(trim_q),
    .o_sec(sec_tick),
    .o_half(half_tick),
    .o_half_flag(half_flag), // (R5)
    .o_near_roll(near_roll)
  );

  // Years 00..99 stand for 2000..2099, every fourth one is leap.
  assign leap = fval[F_YEAR][4] // (R21)
    ? (fval[F_YEAR][3:0] == 4'h2 || fval[F_YEAR][3:0] == 4'h6)
    : (fval[F_YEAR][3:0] == 4'h0 || fval[F_YEAR][3:0] == 4'h4
       || fval[F_YEAR][3:0] == 4'h8);

  always_comb begin
    case (fval[F_MONTH])
      8'h02: day_max = leap ? DAYS_29 : DAYS_28; // (R21)
      8'h04, 8'h06, 8'h09, 8'h11: day_max = DAYS_30;
      default: day_max = DAYS_31;
    endcase
  end

  assign carry[0] = sec_tick;

  for (genvar i = 0; i < 6; i++) begin : g_field
    assign carry[i + 1] = carry[i] & at_max[i];
    // Seconds and minutes count 00..59 in BCD. (R22)
    bcd_field #(
      .RESET_VAL(FIELD_MIN[i])
    ) u_field (
      .i_clk(i_clk),
      .i_reset(i_reset),
      .i_ce(i_ce),
      .i_inc(carry[i]),
      .i_load(t_load && tw_slot == 3'(i)),
      .i_load_val(wdata & FIELD_MASK[i]),
      .i_min(FIELD_MIN[i]),
      .i_max((3'(i) == F_DAY) ? day_max : FIELD_MAX[i]),
      .o_value(fval[i]),
      .o_at_max(at_max[i])
    );
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      wday_q <= 3'h0;
    end else if (i_ce) begin
      if (t_load && tw_slot == F_WDAY) begin
        wday_q <= wdata[2:0];
      end else if (carry[F_DAY]) begin
        wday_q <= (wday_q >= WDAY_MAX) ? 3'h0 : wday_q + 3'h1;
      end
    end
  end

  // ********************************************************
  // Alarm
  // ********************************************************
  logic alm_en_q;
  logic chime_q;
  logic [3:0] ivl_q;
  logic [1:0] aptr_q;
  logic [7:0] rpt_q;
  logic [7:0] alm_q [7];
  logic [2:0] aw_slot;
  logic chk_sec_q;
  logic chk_half_q;
  logic match;
  logic alarm_ev;
  logic alm_pin_q;
  logic eq_s;
  logic eq_m;
  logic eq_h;

  assign aw_slot = slot(addr == OFS_AW_HI, aptr_q, 1'b1);
  assign eq_s = fval[F_SEC] == alm_q[F_SEC];
  assign eq_m = fval[F_MIN] == alm_q[F_MIN];
  assign eq_h = fval[F_HOUR] == alm_q[F_HOUR];

  // Compare one cycle after a tick, once the fields have moved.
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      chk_sec_q <= 1'b0;
      chk_half_q <= 1'b0;
    end else if (i_ce) begin
      chk_sec_q <= sec_tick;
      chk_half_q <= half_tick;
    end
  end

  always_comb begin
    case (ivl_q) // (R17)
      IVL_HALF: match = chk_half_q | chk_sec_q;
      IVL_SEC: match = chk_sec_q;
      IVL_10SEC: match = chk_sec_q
        && fval[F_SEC][3:0] == alm_q[F_SEC][3:0];
      IVL_MIN: match = chk_sec_q && eq_s;
      IVL_10MIN: match = chk_sec_q && eq_s
        && fval[F_MIN][3:0] == alm_q[F_MIN][3:0];
      IVL_HOUR: match = chk_sec_q && eq_s && eq_m;
      IVL_DAY: match = chk_sec_q && eq_s && eq_m && eq_h;
      IVL_WEEK: match = chk_sec_q && eq_s && eq_m && eq_h
        && {5'h00, wday_q} == alm_q[F_WDAY];
      IVL_MONTH: match = chk_sec_q && eq_s && eq_m && eq_h
        && fval[F_DAY] == alm_q[F_DAY];
      // Feb 29 exists only in leap years, so it fires every fourth.
      IVL_YEAR: match = chk_sec_q && eq_s && eq_m && eq_h // (R18)
        && fval[F_DAY] == alm_q[F_DAY]
        && fval[F_MONTH] == alm_q[F_MONTH];
      default: match = 1'b0;
    endcase
  end

  assign alarm_ev = alm_en_q & match; // (R23)

  // A software write in the same cycle as an event wins.
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      alm_en_q <= 1'b0;
      chime_q <= 1'b0;
      ivl_q <= 4'h0;
      aptr_q <= 2'h0;
      rpt_q <= REG_RESET;
    end else if (i_ce) begin
      if (alarm_ev && rpt_q != 8'h00) begin
        rpt_q <= rpt_q - 8'h01; // (R14) (R15)
      end else if (alarm_ev && chime_q) begin
        rpt_q <= 8'hFF; // (R16)
      end else if (alarm_ev) begin
        alm_en_q <= 1'b0; // (R13)
      end
      if (wr && addr == OFS_ALM_CFG) begin
        alm_en_q <= wdata[ALM_EN];
        chime_q <= wdata[ALM_CHIME];
        ivl_q <= wdata[5:2];
        aptr_q <= wdata[1:0];
      end else if (fire && addr == OFS_AW_HI && aptr_q != 2'h0) begin
        aptr_q <= aptr_q - 2'h1; // (R19)
      end
      if (wr && addr == OFS_RPT) begin
        rpt_q <= wdata;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      for (int k = 0; k < 7; k++) begin
        alm_q[k] <= REG_RESET;
      end
    end else if (i_ce) begin
      if (wr && unlock_q && aw_slot != F_NONE // (R20)
          && (addr == OFS_AW_HI || addr == OFS_AW_LO)) begin
        alm_q[aw_slot] <= wdata & FIELD_MASK[aw_slot];
      end
    end
  end

  // The alarm pulse lasts until the next half-second boundary.
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      alm_pin_q <= 1'b0;
    end else if (i_ce) begin
      if (alarm_ev) begin
        alm_pin_q <= 1'b1;
      end else if (half_tick || sec_tick) begin
        alm_pin_q <= 1'b0;
      end
    end
  end

  // ********************************************************
  // Pin output
  // ********************************************************
  logic pin_q;
  logic pin_oe_n_q;

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      pin_q <= 1'b0;
      pin_oe_n_q <= 1'b1;
    end else if (i_ce) begin
      pin_oe_n_q <= ~oe_q; // (R7)
      case (sel_q) // (R12)
        SEL_ALARM: pin_q <= oe_q & alm_pin_q;
        SEL_SECONDS: pin_q <= oe_q & ~half_flag;
        SEL_SOURCE: pin_q <= oe_q & tk_s2_q;
        default: pin_q <= 1'b0;
      endcase
    end
  end

  // ********************************************************
  // Read path and bus answer
  // ********************************************************
  logic [7:0] rd_val;
  logic hit;
  logic [2:0] rs;

  function automatic logic [7:0] time_at(input logic [2:0] s);
    return (s == F_NONE) ? 8'h00 :
      (s == F_WDAY) ? {5'h00, wday_q} : fval[s];
  endfunction

  always_comb begin
    hit = 1'b1;
    rs = F_NONE;
    rd_val = 8'h00;
    case (addr)
      OFS_CONFIG: rd_val = {on_q, 1'b0, unlock_q,
        near_roll | chk_sec_q, half_flag, oe_q, tptr_q}; // (R4)
      OFS_TRIM: rd_val = trim_q;
      OFS_PIN: rd_val = {5'h00, sel_q, 1'b0};
      OFS_ALM_CFG: rd_val = {alm_en_q, chime_q, ivl_q, aptr_q};
      OFS_RPT: rd_val = rpt_q;
      OFS_TW_HI, OFS_TW_LO: rd_val = time_at(tw_slot); // (R9)
      OFS_AW_HI, OFS_AW_LO: begin
        rs = aw_slot;
        rd_val = (rs == F_NONE) ? 8'h00 : alm_q[rs];
      end
      default: hit = 1'b0;
    endcase
  end

  // Other resets only drop a bus answer in flight.
  always_ff @(posedge i_clk) begin
    if (i_reset || i_sys_reset) begin
      pready_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end else if (i_ce) begin
      pready_q <= i_apb.psel & i_apb.penable & ~pready_q;
      if (i_apb.psel && i_apb.penable && !pready_q) begin
        prdata_q <= i_apb.pwrite ? 32'h0000_0000 : {24'h000000, rd_val};
        pslverr_q <= ~hit;
      end
    end
  end

  assign o_apb.pready = pready_q;
  assign o_apb.prdata = prdata_q;
  assign o_apb.pslverr = pslverr_q;
  assign o_rtc_pin = pin_q;
  assign o_rtc_pin_oe_n = pin_oe_n_q;

endmodule // rtc_control
`default_nettype wire

//--- hw/rtc_pkg.sv
`default_nettype none
package rtc_pkg;

  // ********************************************************
  // Register map, one aligned 32-bit word per register
  // ********************************************************
  localparam logic [11:0] OFS_CONFIG = 12'h000;
  localparam logic [11:0] OFS_TRIM = 12'h004;
  localparam logic [11:0] OFS_PIN = 12'h008;
  localparam logic [11:0] OFS_ALM_CFG = 12'h00C;
  localparam logic [11:0] OFS_RPT = 12'h010;
  localparam logic [11:0] OFS_TW_HI = 12'h014;
  localparam logic [11:0] OFS_TW_LO = 12'h018;
  localparam logic [11:0] OFS_AW_HI = 12'h01C;
  localparam logic [11:0] OFS_AW_LO = 12'h020;

  localparam int CFG_ON = 7;
  localparam int CFG_UNLOCK = 5;
  localparam int CFG_ROLL = 4;
  localparam int CFG_HALF = 3;
  localparam int CFG_OE = 2;
  localparam int ALM_EN = 7;
  localparam int ALM_CHIME = 6;
  localparam logic [7:0] REG_RESET = 8'h00;

  // ********************************************************
  // Prescaler counts in timekeeping clock pulses
  // ********************************************************
  localparam logic [14:0] PRE_LAST = 15'h7FFF;
  localparam logic [14:0] PRE_HALF_LAST = 15'h3FFF;
  localparam logic [14:0] PRE_WARN = 15'h7FE0;

  localparam logic [1:0] SEL_ALARM = 2'h0;
  localparam logic [1:0] SEL_SECONDS = 2'h1;
  localparam logic [1:0] SEL_SOURCE = 2'h2;

  localparam logic [3:0] IVL_HALF = 4'h0;
  localparam logic [3:0] IVL_SEC = 4'h1;
  localparam logic [3:0] IVL_10SEC = 4'h2;
  localparam logic [3:0] IVL_MIN = 4'h3;
  localparam logic [3:0] IVL_10MIN = 4'h4;
  localparam logic [3:0] IVL_HOUR = 4'h5;
  localparam logic [3:0] IVL_DAY = 4'h6;
  localparam logic [3:0] IVL_WEEK = 4'h7;
  localparam logic [3:0] IVL_MONTH = 4'h8;
  localparam logic [3:0] IVL_YEAR = 4'h9;

  // ********************************************************
  // Calendar fields, BCD
  // ********************************************************
  localparam logic [2:0] F_SEC = 3'h0;
  localparam logic [2:0] F_MIN = 3'h1;
  localparam logic [2:0] F_HOUR = 3'h2;
  localparam logic [2:0] F_DAY = 3'h3;
  localparam logic [2:0] F_MONTH = 3'h4;
  localparam logic [2:0] F_YEAR = 3'h5;
  localparam logic [2:0] F_WDAY = 3'h6;
  localparam logic [2:0] F_NONE = 3'h7;
  localparam logic [7:0] FIELD_MIN [6] =
    '{8'h00, 8'h00, 8'h00, 8'h01, 8'h01, 8'h00};
  localparam logic [7:0] FIELD_MAX [6] =
    '{8'h59, 8'h59, 8'h23, 8'h31, 8'h12, 8'h99};
  localparam logic [7:0] FIELD_MASK [7] =
    '{8'h7F, 8'h7F, 8'h3F, 8'h3F, 8'h1F, 8'hFF, 8'h07};
  localparam logic [2:0] WDAY_MAX = 3'h6;
  localparam logic [7:0] DAYS_28 = 8'h28;
  localparam logic [7:0] DAYS_29 = 8'h29;
  localparam logic [7:0] DAYS_30 = 8'h30;
  localparam logic [7:0] DAYS_31 = 8'h31;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } apb_req_s;

  typedef struct packed {
    logic pready;
    logic [31:0] prdata;
    logic pslverr;
  } apb_rsp_s;

endpackage
`default_nettype wire

//--- hw/tick_prescaler.sv
`timescale 1ns/100ps
`default_nettype none
module tick_prescaler
  import rtc_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_ce,
  input wire logic i_tick,
  input wire logic i_run,
  input wire logic i_clear,
  input wire logic i_sec_at_max,
  input wire logic [7:0] i_trim,
  output logic o_sec,
  output logic o_half,
  output logic o_half_flag,
  output logic o_near_roll
);
  logic [14:0] cnt_q;
  logic [9:0] debt_q;
  logic step;
  logic [7:0] neg_trim;

  assign step = i_tick & i_run & (debt_q == 10'h000);
  assign o_sec = step & (cnt_q == PRE_LAST);
  assign o_half = step & (cnt_q == PRE_HALF_LAST);
  assign o_half_flag = cnt_q[14];
  assign o_near_roll = (cnt_q >= PRE_WARN);
  assign neg_trim = 8'h00 - i_trim;

  always_ff @(posedge i_clk) begin
    if (i_reset || (i_ce && i_clear)) begin
      cnt_q <= 15'h0000;
      debt_q <= 10'h000;
    end else if (i_ce && i_tick && i_run) begin
      if (debt_q != 10'h000) begin
        debt_q <= debt_q - 10'h001;
      end else if (cnt_q == PRE_LAST) begin
        cnt_q <= 15'h0000;
        // Trim is settled once per minute, at its first second.
        if (i_sec_at_max && !i_trim[7]) begin // (R24)
          cnt_q <= {6'h00, i_trim[6:0], 2'h0}; // (R11)
        end else if (i_sec_at_max) begin
          debt_q <= {neg_trim, 2'h0}; // (R11)
        end
      end else begin
        cnt_q <= cnt_q + 15'h0001;
      end
    end
  end
endmodule // tick_prescaler
`default_nettype wire
